// [rtl/bmr_boot_ctrl.sv]
// boot mode selection, reset release and program start of the core
// Function
// RULE_01: byte-rom select high, link select low: EPROM boot, pin drives chip select.
// RULE_02: both selects low, boot memory select input high: host processor boot.
// RULE_03: both selects low, boot memory select low: no boot, run external memory.
// RULE_04: one instruction per input clock period.
// RULE_05: clock source keeps input clock running steady, never stopped or slowed.
// RULE_06: reset gives known state; execution starts at the reset vector.
// RULE_07: reset source holds hardware reset asserted through power-up.
// RULE_08: test reset is pulsed low after power-up or held low.
// RULE_09: test clock is asynchronous; test mode steps the test state machine.
// RULE_10: scan path shifts test data in and serial output out.
// RULE_11: link select tied low; all configuration pins are hardwired.
// RULE_12: sample configuration during reset; release reset synchronously before boot.
`timescale 1ns/1ps

module bmr_boot_ctrl
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic byte_rom_boot_select_in,
    input wire logic link_boot_select_in,
    input wire logic boot_memory_select_in,
    output logic boot_memory_select_out,
    output logic boot_memory_select_oe_n_out,
    input wire logic eprom_done_in,
    input wire logic host_done_in,
    output bmr_pkg::bmr_status_t status_out,
    output logic [bmr_pkg::PC_WIDTH-1:0] pc_out,
    input wire logic test_clock_in,
    input wire logic test_mode_in,
    input wire logic test_data_in,
    input wire logic test_reset_n_in,
    output logic test_data_out,
    output logic emulation_status_out,
    output logic emulation_status_oe_n_out
);
    import bmr_pkg::*;

    // =====================================================================
    // reset release synchronised to the input clock
    // =====================================================================
    logic [SYNC_STAGES-1:0] rst_sync_r;
    logic core_rst;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rst_sync_r <= '1;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b0}; // [RULE_12]
        end
    end

    assign core_rst = rst_sync_r[SYNC_STAGES-1];

    // =====================================================================
    // configuration capture while the core is still held in reset
    // =====================================================================
    bmr_cfg_t cfg_r;
    bmr_cfg_t cfg_pins;

    assign cfg_pins = '{byte_rom_boot_select: byte_rom_boot_select_in,
                        link_boot_select: link_boot_select_in,
                        boot_memory_select: boot_memory_select_in};

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_r <= '0;
        end
        else if (core_rst)
        begin
            cfg_r <= cfg_pins; // [RULE_12]
        end
    end

    // =====================================================================
    // mode decode
    // =====================================================================
    wire sel_eprom = cfg_r.byte_rom_boot_select & ~cfg_r.link_boot_select; // [RULE_01]
    wire sel_low = ~cfg_r.byte_rom_boot_select & ~cfg_r.link_boot_select;
    wire sel_host = sel_low & cfg_r.boot_memory_select; // [RULE_02]
    wire cfg_error = cfg_r.link_boot_select; // [RULE_11]
    bmr_mode_t mode;

    // a raised link select is unsupported and falls back to no boot
    assign mode = sel_eprom ? BMR_MODE_EPROM : (sel_host ? BMR_MODE_HOST : BMR_MODE_NONE); // [RULE_03]

    // =====================================================================
    // core sequencing
    // =====================================================================
    bmr_state_t st_r;
    bmr_state_t st_nxt;
    logic [PC_WIDTH-1:0] pc_r;
    logic ext_fetch_r;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            BMR_ST_RESET:
            begin
                if (!core_rst)
                begin
                    case (mode)
                        BMR_MODE_EPROM: st_nxt = BMR_ST_EPROM; // [RULE_01]
                        BMR_MODE_HOST: st_nxt = BMR_ST_HOST; // [RULE_02]
                        default: st_nxt = BMR_ST_RUN; // [RULE_03]
                    endcase
                end
            end
            BMR_ST_EPROM: st_nxt = eprom_done_in ? BMR_ST_RUN : BMR_ST_EPROM;
            BMR_ST_HOST: st_nxt = host_done_in ? BMR_ST_RUN : BMR_ST_HOST;
            default: st_nxt = BMR_ST_RUN;
        endcase
    end

    wire enter_run = (st_r != BMR_ST_RUN) && (st_nxt == BMR_ST_RUN);

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= BMR_ST_RESET; // [RULE_06]
            pc_r <= RESET_VECTOR;
            ext_fetch_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (enter_run)
            begin
                pc_r <= RESET_VECTOR; // [RULE_06]
                ext_fetch_r <= (st_r == BMR_ST_RESET); // [RULE_03]
            end
            else if (st_r == BMR_ST_RUN)
            begin
                pc_r <= pc_r + PC_STEP; // [RULE_04]
            end
        end
    end

    // =====================================================================
    // boot memory select pin: input during reset, driven only in EPROM mode
    // =====================================================================
    wire drive_boot_sel = !core_rst && (mode == BMR_MODE_EPROM);

    assign boot_memory_select_oe_n_out = ~drive_boot_sel; // [RULE_01]
    assign boot_memory_select_out = (st_r != BMR_ST_EPROM); // [RULE_01]

    assign status_out = '{mode: mode, cfg_error: cfg_error,
                          core_run: (st_r == BMR_ST_RUN), ext_fetch: ext_fetch_r};
    assign pc_out = pc_r;

    // =====================================================================
    // test port
    // =====================================================================
    logic scan_active;

    bmr_scan_path u_scan
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .test_clock_in(test_clock_in),
        .test_mode_in(test_mode_in),
        .test_data_in(test_data_in),
        .test_reset_n_in(test_reset_n_in),
        .capture_in({1'b0, st_r, mode, cfg_r}),
        .test_data_out(test_data_out),
        .scan_active_out(scan_active)
    );

    // open drain: pulled low while the scan path is shifting
    assign emulation_status_out = 1'b0;
    assign emulation_status_oe_n_out = ~scan_active;

    // =====================================================================
    // checks
    // =====================================================================
    a_eprom_chip_sel: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_01]
        st_r == BMR_ST_EPROM |-> !boot_memory_select_out && !boot_memory_select_oe_n_out)
        else $error("EPROM chip select not driven during EPROM boot");

    a_host_mode_entry: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_02]
        (st_r == BMR_ST_RESET && !core_rst && sel_host) |=> st_r == BMR_ST_HOST)
        else $error("host boot not selected");

    a_no_boot_run: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_03]
        (st_r == BMR_ST_RESET && !core_rst && sel_low && !cfg_r.boot_memory_select)
        |=> st_r == BMR_ST_RUN && ext_fetch_r && boot_memory_select_oe_n_out)
        else $error("no boot mode did not start from external memory");

    a_pc_per_clock: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_04]
        (st_r == BMR_ST_RUN) ##1 (st_r == BMR_ST_RUN) |-> pc_r == $past(pc_r) + PC_STEP)
        else $error("instruction rate differs from input clock");

    a_reset_vector: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_06]
        $rose(st_r == BMR_ST_RUN) |-> pc_r == RESET_VECTOR)
        else $error("execution did not start at the reset vector");

    a_release_delay: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_12]
        $past(rst_sync_r[0]) |-> core_rst && st_r == BMR_ST_RESET)
        else $error("reset released without synchronisation");

    a_cfg_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_12]
        (!core_rst ##1 !core_rst) |-> $stable(cfg_r))
        else $error("configuration changed after reset release");

    a_eprom_to_run: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_06]
        (st_r == BMR_ST_EPROM && eprom_done_in)
        |=> st_r == BMR_ST_RUN && pc_r == RESET_VECTOR && boot_memory_select_out)
        else $error("EPROM boot did not hand over to the reset vector");

    a_host_to_run: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_02]
        (st_r == BMR_ST_HOST && host_done_in) |=> st_r == BMR_ST_RUN && !ext_fetch_r)
        else $error("host boot did not end in program execution");

    a_ext_fetch_mode: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_03]
        ext_fetch_r |-> mode == BMR_MODE_NONE && st_r == BMR_ST_RUN)
        else $error("external fetch flagged outside no boot mode");

endmodule

// [rtl/bmr_pkg.sv]
// shared types and constants of the boot mode and reset controller
package bmr_pkg;

    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] TMS_RESET_ONES = 3'h5;

    // =====================================================================
    // program sequencing
    // =====================================================================
    localparam int PC_WIDTH = 24;
    localparam logic [23:0] RESET_VECTOR = 24'h000008;
    localparam logic [23:0] PC_STEP = 24'h000001;

    // =====================================================================
    // boundary scan path
    // =====================================================================
    localparam int BSR_WIDTH = 8;
    localparam logic [7:0] BSR_RESET = 8'h00;

    // =====================================================================
    // boot modes, core states and test states
    // =====================================================================
    typedef enum logic [1:0]
    {
        BMR_MODE_NONE = 2'b00,
        BMR_MODE_EPROM = 2'b01,
        BMR_MODE_HOST = 2'b10
    } bmr_mode_t;

    typedef enum logic [1:0]
    {
        BMR_ST_RESET = 2'b00,
        BMR_ST_EPROM = 2'b01,
        BMR_ST_HOST = 2'b10,
        BMR_ST_RUN = 2'b11
    } bmr_state_t;

    typedef enum logic [1:0]
    {
        BMR_TS_RESET = 2'b00,
        BMR_TS_IDLE = 2'b01,
        BMR_TS_SHIFT = 2'b10
    } bmr_tstate_t;

    // captured configuration pins
    typedef struct packed
    {
        logic byte_rom_boot_select;
        logic link_boot_select;
        logic boot_memory_select;
    } bmr_cfg_t;

    // status towards the core
    typedef struct packed
    {
        bmr_mode_t mode;
        logic cfg_error;
        logic core_run;
        logic ext_fetch;
    } bmr_status_t;

endpackage

// [rtl/bmr_scan_path.sv]
// test port: synchronised test clock, small test state machine, scan path
`timescale 1ns/1ps

module bmr_scan_path
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic test_clock_in,
    input wire logic test_mode_in,
    input wire logic test_data_in,
    input wire logic test_reset_n_in,
    input wire logic [bmr_pkg::BSR_WIDTH-1:0] capture_in,
    output logic test_data_out,
    output logic scan_active_out
);
    import bmr_pkg::*;

    // =====================================================================
    // synchronisers: the test clock is asynchronous to the input clock
    // =====================================================================
    logic [1:0] tck_sync_r;
    logic [1:0] trst_sync_r;
    logic tck_last_r;
    logic [2:0] ones_r;
    logic [BSR_WIDTH-1:0] bsr_r;
    logic tdo_r;
    bmr_tstate_t ts_r;
    bmr_tstate_t ts_nxt;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tck_sync_r <= 2'h0;
            trst_sync_r <= 2'h0;
            tck_last_r <= 1'b0;
        end
        else
        begin
            tck_sync_r <= {tck_sync_r[0], test_clock_in}; // [RULE_09]
            trst_sync_r <= {trst_sync_r[0], test_reset_n_in};
            tck_last_r <= tck_sync_r[1];
        end
    end

    wire tck_rise = tck_sync_r[1] & ~tck_last_r;
    wire tck_fall = ~tck_sync_r[1] & tck_last_r;
    wire trst_act = ~trst_sync_r[1];
    wire tms_reset = (ones_r == TMS_RESET_ONES - 3'h1) & test_mode_in;

    // =====================================================================
    // test state machine, stepped on test clock rising edges
    // =====================================================================
    always_comb
    begin
        ts_nxt = ts_r;
        case (ts_r)
            BMR_TS_RESET: ts_nxt = test_mode_in ? BMR_TS_RESET : BMR_TS_IDLE;
            BMR_TS_IDLE: ts_nxt = test_mode_in ? BMR_TS_IDLE : BMR_TS_SHIFT;
            BMR_TS_SHIFT: ts_nxt = test_mode_in ? BMR_TS_IDLE : BMR_TS_SHIFT;
            default: ts_nxt = BMR_TS_RESET;
        endcase
        if (tms_reset)
        begin
            ts_nxt = BMR_TS_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ts_r <= BMR_TS_RESET;
            ones_r <= 3'h0;
            bsr_r <= BSR_RESET;
            tdo_r <= 1'b0;
        end
        else if (trst_act)
        begin
            ts_r <= BMR_TS_RESET;
            ones_r <= 3'h0;
            bsr_r <= BSR_RESET;
            tdo_r <= 1'b0;
        end
        else
        begin
            if (tck_rise)
            begin
                ts_r <= ts_nxt; // [RULE_09]
                ones_r <= (test_mode_in && !tms_reset) ? ones_r + 3'h1 : 3'h0;
                if (ts_r == BMR_TS_SHIFT && !test_mode_in)
                begin
                    bsr_r <= {test_data_in, bsr_r[BSR_WIDTH-1:1]}; // [RULE_10]
                end
                else if (ts_r == BMR_TS_IDLE && !test_mode_in)
                begin
                    bsr_r <= capture_in;
                end
            end
            if (tck_fall)
            begin
                tdo_r <= bsr_r[0]; // [RULE_10]
            end
        end
    end

    assign test_data_out = tdo_r;
    assign scan_active_out = (ts_r == BMR_TS_SHIFT);

    // =====================================================================
    // checks
    // =====================================================================
    a_tdo_on_fall: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_10]
        (tck_fall && !trst_act) |=> test_data_out == $past(bsr_r[0]))
        else $error("scan output not updated on test clock fall");

    a_scan_shift_in: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_10]
        (tck_rise && !trst_act && ts_r == BMR_TS_SHIFT && !test_mode_in)
        |=> bsr_r[BSR_WIDTH-1] == $past(test_data_in))
        else $error("scan data not shifted in");

    a_tms_to_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE_09]
        (tck_rise && tms_reset) |=> ts_r == BMR_TS_RESET)
        else $error("test mode ones did not reset the test state");

endmodule

// [tb/bmr_boot_partner.sv]
// boot memory, host and strap model at the far side of the boot controller
`timescale 1ns/1ps

module bmr_boot_partner
(
    input wire logic clk_sys_in,
    input wire logic strap_boot_sel_in,
    input wire logic cs_n_in,
    input wire logic cs_oe_n_in,
    input wire bmr_pkg::bmr_status_t status_in,
    input wire logic [7:0] boot_delay_in,
    output logic boot_sel_pin_out,
    output logic eprom_done_out,
    output logic host_done_out
);
    import bmr_pkg::*;

    logic [7:0] cnt_r = 8'h00;
    wire eprom_sel = (cs_oe_n_in == 1'b0) && (cs_n_in == 1'b0);
    wire host_busy = (status_in.mode == BMR_MODE_HOST) && (status_in.core_run == 1'b0);

    // pin carries the device drive while enabled, else the hardwired strap
    assign boot_sel_pin_out = cs_oe_n_in ? strap_boot_sel_in : cs_n_in;

    // loader finishes a programmable number of cycles after it is engaged
    always @(negedge clk_sys_in)
    begin
        cnt_r <= (eprom_sel || host_busy) ? cnt_r + 8'h01 : 8'h00;
        eprom_done_out <= eprom_sel && (cnt_r >= boot_delay_in);
        host_done_out <= host_busy && (cnt_r >= boot_delay_in);
    end
endmodule

// [tb/boot_mode_reset_control_tb.sv]
// self-checking bench of the boot mode and reset controller
`timescale 1ns/1ps

module boot_mode_reset_control_tb;
    import bmr_pkg::*;

    typedef struct packed
    {
        logic e;
        logic l;
        logic b;
        logic [7:0] d;
        bmr_mode_t m;
        logic err;
        logic ext;
    } bmr_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ebt = 1'b0;
    logic lbt = 1'b0;
    logic strap_boot_sel = 1'b0;
    logic [7:0] dly = 8'h00;
    logic tck = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b1;
    logic trst_n = 1'b0;
    logic boot_sel_pin, boot_sel, boot_sel_oe_n, eprom_done, host_done, tdo;
    logic emulation_status, emulation_status_oe_n;
    bmr_status_t status;
    logic [PC_WIDTH-1:0] pc;
    logic [7:0] bits;
    int n_fail = 0;
    int tests_run = 0;

    bmr_row_t rows [4] = '{
        '{1'h1, 1'h0, 1'h1, 8'h00, BMR_MODE_EPROM, 1'h0, 1'h0},
        '{1'h0, 1'h0, 1'h1, 8'h14, BMR_MODE_HOST, 1'h0, 1'h0},
        '{1'h0, 1'h1, 1'h0, 8'h00, BMR_MODE_NONE, 1'h1, 1'h1},
        '{1'h0, 1'h0, 1'h0, 8'h00, BMR_MODE_NONE, 1'h0, 1'h1}};

    always #5 clk = ~clk;

    bmr_boot_ctrl uut
    (
        .clk_sys_in(clk),
        .rst_in(rst),
        .byte_rom_boot_select_in(ebt),
        .link_boot_select_in(lbt),
        .boot_memory_select_in(boot_sel_pin),
        .boot_memory_select_out(boot_sel),
        .boot_memory_select_oe_n_out(boot_sel_oe_n),
        .eprom_done_in(eprom_done),
        .host_done_in(host_done),
        .status_out(status),
        .pc_out(pc),
        .test_clock_in(tck),
        .test_mode_in(tms),
        .test_data_in(tdi),
        .test_reset_n_in(trst_n),
        .test_data_out(tdo),
        .emulation_status_out(emulation_status),
        .emulation_status_oe_n_out(emulation_status_oe_n)
    );

    bmr_boot_partner partner
    (
        .clk_sys_in(clk),
        .strap_boot_sel_in(strap_boot_sel),
        .cs_n_in(boot_sel),
        .cs_oe_n_in(boot_sel_oe_n),
        .status_in(status),
        .boot_delay_in(dly),
        .boot_sel_pin_out(boot_sel_pin),
        .eprom_done_out(eprom_done),
        .host_done_out(host_done)
    );

    // =====================================================================
    // compare and report
    // =====================================================================
    task automatic summarize;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // =====================================================================
    // sequences
    // =====================================================================
    task automatic wait_run;
        int n;
        n = 0;
        while (status.core_run !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 300)
            begin
                n_fail++;
                summarize();
            end
        end
    endtask

    task automatic run_row(input bmr_row_t r);
        @(negedge clk);
        rst = 1'b1;
        ebt = r.e;
        lbt = r.l;
        strap_boot_sel = r.b;
        dly = r.d;
        repeat (16) @(negedge clk);
        check_bit(status.core_run, 1'b0);
        check_bit(boot_sel_oe_n, 1'b1);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check_bit(boot_sel_oe_n, r.m != BMR_MODE_EPROM);
        if (r.m == BMR_MODE_EPROM)
            check_bit(boot_sel, 1'b0);
        wait_run();
        check_word(pc, RESET_VECTOR);
        check_word({22'h0, status.mode}, {22'h0, r.m});
        check_bit(status.cfg_error, r.err);
        check_bit(status.ext_fetch, r.ext);
        check_bit(boot_sel, 1'b1);
        @(negedge clk);
        check_word(pc, RESET_VECTOR + PC_STEP);
    endtask

    task automatic tck_cycle(input logic m, output logic b);
        tms = m;
        tck = 1'b1;
        repeat (5) @(negedge clk);
        tck = 1'b0;
        repeat (5) @(negedge clk);
        b = tdo;
    endtask

    initial
    begin
        for (int i = 0; i < 4; i++)
            run_row(rows[i]);
        // asynchronous reset in mid-run
        @(negedge clk);
        rst = 1'b1;
        #1;
        check_bit(status.core_run, 1'b0);
        check_word(pc, RESET_VECTOR);
        @(negedge clk);
        rst = 1'b0;
        wait_run();
        check_word(pc, RESET_VECTOR);
        // straps moving after release are ignored
        ebt = 1'b1;
        repeat (3) @(negedge clk);
        check_word({22'h0, status.mode}, {22'h0, BMR_MODE_NONE});
        check_bit(boot_sel_oe_n, 1'b1);
        ebt = 1'b0;
        trst_n = 1'b1;
        repeat (4) @(negedge clk);
        // scan path: reset, idle, shift with capture of run state
        tck_cycle(1'b0, bits[0]);
        tck_cycle(1'b0, bits[0]);
        check_bit(emulation_status_oe_n, 1'b0);
        check_bit(emulation_status, 1'b0);
        for (int i = 1; i < 8; i++)
            tck_cycle(1'b0, bits[i]);
        check_word({16'h0, bits}, 24'h000060);
        tck_cycle(1'b1, bits[0]);
        check_bit(emulation_status_oe_n, 1'b1);
        // five test mode highs force reset: one low then only reaches idle
        repeat (5) tck_cycle(1'b1, bits[0]);
        tck_cycle(1'b0, bits[0]);
        check_bit(emulation_status_oe_n, 1'b1);
        tck_cycle(1'b0, bits[0]);
        check_bit(emulation_status_oe_n, 1'b0);
        // test reset in mid-shift returns the test state machine to reset
        trst_n = 1'b0;
        repeat (4) @(negedge clk);
        check_bit(emulation_status_oe_n, 1'b1);
        summarize();
    end
endmodule
